/* File: cbo_pkg.sv */
// Constants and types for the cache-block zero and prefetch unit.
// Assumes a 32-bit instruction word and a byte-addressed memory hierarchy.
// Behaviour
// - Zero every byte of the addressed block
// - Block may be cleared in several writes
// - Prefetch address is base plus sign-extended immediate
// - Fetch hint may fill instruction cache
// - Read hint may fill load cache
// - Write hint may fill store cache
// - Hints are immediate-OR, rd zero, kind field
// - Destination field supplies immediate bits 4:0
// - Translate effective address before acting
package cbo_pkg;

    // Major opcodes
    localparam logic [6:0] OPC_MISC_MEM = 7'h0f;
    localparam logic [6:0] OPC_IMM_ALU = 7'h13;
    // Minor function codes
    localparam logic [2:0] F3_CBO = 3'h2;
    localparam logic [2:0] F3_OR_IMM = 3'h6;
    // Sub-op for block-zero in bits 31:20
    localparam logic [11:0] CBO_ZERO_FN = 12'h004;
    // Hint selectors in bits 24:20
    localparam logic [4:0] HINT_FETCH = 5'h00;
    localparam logic [4:0] HINT_READ = 5'h01;
    localparam logic [4:0] HINT_WRITE = 5'h03;
    // Field positions
    localparam int OPC_LSB = 0;
    localparam int RD_LSB = 7;
    localparam int F3_LSB = 12;
    localparam int RS2_LSB = 20;
    localparam int IMM_HI_LSB = 25;
    // Memory-side operation codes
    localparam logic [1:0] MEM_ZERO = 2'h0;
    localparam logic [1:0] MEM_PF_I = 2'h1;
    localparam logic [1:0] MEM_PF_R = 2'h2;
    localparam logic [1:0] MEM_PF_W = 2'h3;
    // Values after reset
    localparam logic RST_PULSE = 1'b0;
    localparam logic [1:0] RST_MEM_OP = 2'h0;

    // Decoded operation kind
    typedef enum logic [2:0] {
        OP_NONE,
        OP_ZERO,
        OP_PF_I,
        OP_PF_R,
        OP_PF_W
    } op_kind_t;

endpackage : cbo_pkg

/* File: cbo_op_if.sv */
// Carrier for a decoded operation from the decoder to the sequencer.
// Assumes both ends sit in the same clock domain; contents are combinational.
interface cbo_op_if #(
    parameter int XLEN = 32
);
    logic hit; // Instruction is one of ours
    cbo_pkg::op_kind_t kind; // Which operation
    logic [XLEN-1:0] vaddr; // Effective (virtual) address

    modport producer (output hit, output kind, output vaddr);
    modport consumer (input hit, input kind, input vaddr);
endinterface : cbo_op_if

/* File: cbo_decode.sv */
// Combinational decoder for block-zero and the three prefetch hints.
// Assumes the base register value is already read from the register file.
module cbo_decode #(
    parameter int XLEN = 32
) (
    input wire logic [31:0] insn_in,
    input wire logic [XLEN-1:0] base_source_reg_in,
    cbo_op_if.producer op
);

    // Classify one instruction word
    function automatic cbo_pkg::op_kind_t classify(input logic [31:0] w);
        cbo_pkg::op_kind_t k;
        k = cbo_pkg::OP_NONE;
        if (w[6:0] == cbo_pkg::OPC_MISC_MEM && w[14:12] == cbo_pkg::F3_CBO &&
            w[11:7] == 5'h00 && w[31:20] == cbo_pkg::CBO_ZERO_FN) begin
            k = cbo_pkg::OP_ZERO;
        end else if (w[6:0] == cbo_pkg::OPC_IMM_ALU && w[14:12] == cbo_pkg::F3_OR_IMM &&
                     w[11:7] == 5'h00) begin
            unique case (w[24:20])
                cbo_pkg::HINT_FETCH: k = cbo_pkg::OP_PF_I;
                cbo_pkg::HINT_READ: k = cbo_pkg::OP_PF_R;
                cbo_pkg::HINT_WRITE: k = cbo_pkg::OP_PF_W;
                // Any other selector is a plain OR with rd zero, not ours
                default: k = cbo_pkg::OP_NONE;
            endcase
        end
        return k;
    endfunction : classify

    logic [11:0] imm; // Store-style immediate
    cbo_pkg::op_kind_t kind; // Decoded kind

    // rd field gives the low immediate bits
    assign imm = {insn_in[31:cbo_pkg::IMM_HI_LSB], insn_in[11:cbo_pkg::RD_LSB]};
    assign kind = classify(insn_in);
    assign op.kind = kind;
    assign op.hit = (kind != cbo_pkg::OP_NONE);

    // Address generation
    always_comb begin
        if (kind == cbo_pkg::OP_ZERO) begin
            op.vaddr = base_source_reg_in;
        end else begin
            op.vaddr = base_source_reg_in + {{(XLEN-12){imm[11]}}, imm};
        end
    end

endmodule : cbo_decode

/* File: cbo_unit.sv */
// Top of the cache-block zero and prefetch unit.
// Assumes the pipeline offers one instruction at a time with its base value,
// a translation port answering with a physical address or a fault, and a
// cache port that accepts one request per acknowledge.
module cbo_unit #(
    parameter int XLEN = 32, // Address width
    parameter int BLOCK_BYTES = 64, // Cache block size
    parameter int BEAT_BYTES = 8, // Bytes cleared per write
    parameter bit PREFETCH_EN = 1'b1 // Forward hints to the cache
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic insn_valid_in,
    input wire logic [31:0] insn_in,
    input wire logic [XLEN-1:0] base_source_reg_in,
    output logic insn_ready_out,
    output logic insn_hit_out,
    output logic done_out,
    output logic fault_out,
    output logic xlate_req_out,
    output logic [XLEN-1:0] xlate_vaddr_out,
    input wire logic xlate_ack_in,
    input wire logic [XLEN-1:0] xlate_paddr_in,
    input wire logic xlate_fault_in,
    output logic mem_req_out,
    output logic [1:0] mem_op_out,
    output logic [XLEN-1:0] mem_addr_out,
    output logic [8*BEAT_BYTES-1:0] mem_data_out,
    input wire logic mem_ack_in
);

    localparam int OFF_W = $clog2(BLOCK_BYTES); // Block offset bits
    localparam int BEATS = BLOCK_BYTES / BEAT_BYTES; // Writes per block
    localparam int BEAT_W = (BEATS > 1) ? $clog2(BEATS) : 1; // Beat counter width
    localparam logic [XLEN-1:0] BEAT_STEP = XLEN'(BEAT_BYTES); // Address step per write

    // Refuse shapes the beat walk cannot serve, at elaboration time
    if (XLEN < 32 || BLOCK_BYTES < BEAT_BYTES || BEAT_BYTES < 1 ||
        (BLOCK_BYTES & (BLOCK_BYTES - 1)) != 0 || (BEAT_BYTES & (BEAT_BYTES - 1)) != 0 ||
        OFF_W >= XLEN) begin : g_bad_params
        $error("cbo_unit: unsupported parameter set");
    end

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_XLATE,
        ST_ZERO,
        ST_PREF
    } state_t;

    state_t state_q; // Sequencer state
    cbo_pkg::op_kind_t kind_q; // Operation in flight
    logic [XLEN-1:0] vaddr_q; // Effective address held for translation
    logic [XLEN-1:0] addr_q; // Current cache-side address
    logic [1:0] op_q; // Current cache-side op code
    logic [BEAT_W-1:0] beat_q; // Beats of the block already cleared
    logic done_q; // Completion pulse
    logic fault_q; // Translation fault pulse
    logic accept; // Instruction taken this cycle
    logic xl_ok; // Translation answered without fault
    logic last_beat; // Final write of the block
    logic [XLEN-1:0] block_pa; // Translated address aligned to the block

    cbo_op_if #(.XLEN(XLEN)) op_bus ();

    // Decoder is pure logic; the instruction is held by the pipeline while valid
    cbo_decode #(.XLEN(XLEN)) u_decode (
        .insn_in(insn_in),
        .base_source_reg_in(base_source_reg_in),
        .op(op_bus.producer)
    );

    assign insn_ready_out = (state_q == ST_IDLE);
    assign insn_hit_out = op_bus.hit;
    assign accept = ce_in && insn_valid_in && op_bus.hit && (state_q == ST_IDLE);
    assign xl_ok = xlate_ack_in && !xlate_fault_in;
    assign last_beat = (beat_q == BEAT_W'(BEATS - 1));
    // the whole block, whatever offset the address carries
    assign block_pa = {xlate_paddr_in[XLEN-1:OFF_W], {OFF_W{1'b0}}};

    // Handshake outputs come straight from the state
    assign xlate_req_out = (state_q == ST_XLATE);
    assign mem_req_out = (state_q == ST_ZERO) || (state_q == ST_PREF);
    assign xlate_vaddr_out = vaddr_q;
    assign mem_addr_out = addr_q;
    assign mem_op_out = op_q;
    assign mem_data_out = '0;
    assign done_out = done_q;
    assign fault_out = fault_q;

    // Sequencer: take, translate, then act on the cache
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state_q <= ST_IDLE;
        end else if (ce_in) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= ST_XLATE;
                    end
                end
                // nothing reaches the cache before translation
                ST_XLATE: begin
                    if (xlate_ack_in && xlate_fault_in) begin
                        state_q <= ST_IDLE;
                    end else if (xl_ok && kind_q == cbo_pkg::OP_ZERO) begin
                        state_q <= ST_ZERO;
                    end else if (xl_ok) begin
                        // hints are dropped when forwarding is off
                        state_q <= PREFETCH_EN ? ST_PREF : ST_IDLE;
                    end
                end
                ST_ZERO: begin
                    if (mem_ack_in && last_beat) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_PREF: begin
                    if (mem_ack_in) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Capture of the accepted operation
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            kind_q <= cbo_pkg::OP_NONE;
            vaddr_q <= '0;
        end else if (ce_in && accept) begin
            kind_q <= op_bus.kind;
            vaddr_q <= op_bus.vaddr;
        end
    end

    // Cache-side address and op code
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            addr_q <= '0;
            op_q <= cbo_pkg::RST_MEM_OP;
        end else if (ce_in) begin
            if (state_q == ST_XLATE && xl_ok) begin
                addr_q <= block_pa;
                unique case (kind_q)
                    cbo_pkg::OP_ZERO: op_q <= cbo_pkg::MEM_ZERO;
                    cbo_pkg::OP_PF_I: op_q <= cbo_pkg::MEM_PF_I;
                    cbo_pkg::OP_PF_R: op_q <= cbo_pkg::MEM_PF_R;
                    cbo_pkg::OP_PF_W: op_q <= cbo_pkg::MEM_PF_W;
                    default: op_q <= cbo_pkg::RST_MEM_OP;
                endcase
            // block cleared one beat per write
            end else if (state_q == ST_ZERO && mem_ack_in && !last_beat) begin
                addr_q <= addr_q + BEAT_STEP;
            end
        end
    end

    // Beat counter for the zero walk
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            beat_q <= '0;
        end else if (ce_in) begin
            if (state_q != ST_ZERO) begin
                beat_q <= '0;
            end else if (mem_ack_in && !last_beat) begin
                beat_q <= beat_q + BEAT_W'(1);
            end
        end
    end

    // Completion and fault pulses, one ce_in cycle each; held while ce_in is low
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            done_q <= cbo_pkg::RST_PULSE;
            fault_q <= cbo_pkg::RST_PULSE;
        end else if (ce_in) begin
            done_q <= (state_q == ST_XLATE && xlate_ack_in &&
                       (xlate_fault_in || (kind_q != cbo_pkg::OP_ZERO && !PREFETCH_EN))) ||
                      (state_q == ST_ZERO && mem_ack_in && last_beat) ||
                      (state_q == ST_PREF && mem_ack_in);
            fault_q <= (state_q == ST_XLATE && xlate_ack_in && xlate_fault_in);
        end
    end

    // Checks on the sequencer
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    zero_data_op_a: assert property (
        (state_q == ST_ZERO) |-> (mem_data_out == '0 && mem_op_out == cbo_pkg::MEM_ZERO))
        else $error("zero write carries data or wrong op");

    beat_step_a: assert property (
        (ce_in && state_q == ST_ZERO && mem_ack_in && !last_beat)
        |=> (mem_addr_out == $past(mem_addr_out) + BEAT_STEP) && state_q == ST_ZERO)
        else $error("zero walk address did not step by one beat");

    block_align_a: assert property (
        (state_q == ST_ZERO && beat_q == '0) |-> (mem_addr_out[OFF_W-1:0] == '0))
        else $error("zero walk does not start at block base");

    xlate_first_a: assert property (
        $rose(mem_req_out) |-> $past(state_q) == ST_XLATE && $past(xl_ok))
        else $error("cache request without a translated address");

    zero_base_a: assert property (
        (accept && op_bus.kind == cbo_pkg::OP_ZERO)
        |=> xlate_req_out && xlate_vaddr_out == $past(base_source_reg_in))
        else $error("block-zero address is not the base register");

    pref_addr_a: assert property (
        (accept && op_bus.kind != cbo_pkg::OP_ZERO) |=> xlate_vaddr_out ==
        $past(base_source_reg_in) + {{(XLEN-12){$past(insn_in[31])}},
                                     $past(insn_in[31:25]), $past(insn_in[11:7])})
        else $error("prefetch address is not base plus offset");

    hint_read_a: assert property (
        (insn_in[6:0] == cbo_pkg::OPC_IMM_ALU && insn_in[14:12] == cbo_pkg::F3_OR_IMM &&
         insn_in[11:7] == 5'h00 && insn_in[24:20] == cbo_pkg::HINT_READ)
        |-> op_bus.kind == cbo_pkg::OP_PF_R)
        else $error("read hint not recognised");

    pref_op_a: assert property (
        (state_q == ST_PREF && kind_q == cbo_pkg::OP_PF_W) |-> mem_op_out == cbo_pkg::MEM_PF_W)
        else $error("write hint sent with wrong op");

    fault_end_a: assert property (
        (ce_in && state_q == ST_XLATE && xlate_ack_in && xlate_fault_in)
        |=> (fault_out && done_out && state_q == ST_IDLE) ##1 (!done_out || !$past(ce_in)))
        else $error("translation fault not reported once");

    zero_done_c: cover property ((state_q == ST_ZERO && mem_ack_in && last_beat) ##1 done_out);
    pref_done_c: cover property ((state_q == ST_PREF && mem_ack_in) ##1 done_out);
    fault_c: cover property (fault_out);
    stall_c: cover property ((state_q == ST_ZERO && !ce_in) ##1 (state_q == ST_ZERO));

endmodule : cbo_unit

/* File: cbo_far_model.sv */
// Far-side model: address translation and cache acknowledge for cbo_unit.
// Assumes it shares the unit's clock; answers change on falling edges.
module cbo_far_model #(
    parameter int XLEN = 32,
    parameter logic [31:0] XOFF = 32'h0001_0000 // Virtual to physical offset
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic xlate_req_in,
    input wire logic [XLEN-1:0] xlate_vaddr_in,
    input wire logic mem_req_in,
    input wire logic fault_mode_in, // Bench asks for a translation fault
    input wire logic slow_in, // Bench asks for stalled answers
    output logic xlate_ack_out,
    output logic [XLEN-1:0] xlate_paddr_out,
    output logic xlate_fault_out,
    output logic mem_ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 32'h29b6ce65; // Own stream for stall choices
    logic ack; // Translation answer this cycle
    logic [XLEN-1:0] pa; // Translated address
    // translate effective address
    // Off the answer cycle the address lines show the inverse, never stale data
    always @(negedge sys_clk_in) begin
        ack = resetn_in && xlate_req_in && (!slow_in || (($random(seed) & 3) == 0));
        pa = xlate_vaddr_in + XOFF;
        xlate_ack_out <= ack;
        xlate_paddr_out <= ack ? pa : ~pa;
        xlate_fault_out <= ack ? fault_mode_in : !fault_mode_in;
        mem_ack_out <= resetn_in && mem_req_in && (!slow_in || (($random(seed) & 1) == 0));
    end
endmodule : cbo_far_model

/* File: cbo_unit_tb_top.sv */
// Self-checking bench for cbo_unit with a queue-based model of expected traffic.
// Assumes cbo_far_model answers translation with vaddr + XOFF.
module cbo_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BLK = 32; // Smaller block keeps zero runs short
    localparam int BEAT = 8;
    localparam logic [31:0] XOFF = 32'h0001_0000;
    logic sys_clk_in = 0, resetn_in = 0, ce_in = 1, insn_valid_in = 0;
    logic [31:0] insn_in = 0, base_source_reg_in = 0;
    logic insn_ready_out, insn_hit_out, done_out, fault_out, xlate_req_out;
    logic [31:0] xlate_vaddr_out, xlate_paddr_in, mem_addr_out;
    logic xlate_ack_in, xlate_fault_in, mem_req_out, mem_ack_in;
    logic [1:0] mem_op_out;
    logic [63:0] mem_data_out;
    logic fault_mode = 0, slow = 0; // Partner behaviour chosen per operation
    int seed = 32'h29b6ce65, err_count = 0, samples_checked = 0, beats = 0;
    logic [31:0] vq[$]; // Expected translation requests
    logic [33:0] mq[$]; // Expected cache requests {op, addr}
    logic fq[$]; // Expected fault flag per completion
    int cq[$]; // Expected cache request count per completion
    logic [4:0] sel_t[3] = '{cbo_pkg::HINT_FETCH, cbo_pkg::HINT_READ, cbo_pkg::HINT_WRITE};
    logic [1:0] op_t[3] = '{cbo_pkg::MEM_PF_I, cbo_pkg::MEM_PF_R, cbo_pkg::MEM_PF_W};

    cbo_unit #(.BLOCK_BYTES(BLK), .BEAT_BYTES(BEAT)) dut (.sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in), .ce_in(ce_in), .insn_valid_in(insn_valid_in),
        .insn_in(insn_in), .base_source_reg_in(base_source_reg_in),
        .insn_ready_out(insn_ready_out), .insn_hit_out(insn_hit_out), .done_out(done_out),
        .fault_out(fault_out), .xlate_req_out(xlate_req_out),
        .xlate_vaddr_out(xlate_vaddr_out), .xlate_ack_in(xlate_ack_in),
        .xlate_paddr_in(xlate_paddr_in), .xlate_fault_in(xlate_fault_in),
        .mem_req_out(mem_req_out), .mem_op_out(mem_op_out), .mem_addr_out(mem_addr_out),
        .mem_data_out(mem_data_out), .mem_ack_in(mem_ack_in));
    cbo_far_model #(.XOFF(XOFF)) far (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .xlate_req_in(xlate_req_out), .xlate_vaddr_in(xlate_vaddr_out),
        .mem_req_in(mem_req_out), .fault_mode_in(fault_mode), .slow_in(slow),
        .xlate_ack_out(xlate_ack_in), .xlate_paddr_out(xlate_paddr_in),
        .xlate_fault_out(xlate_fault_in), .mem_ack_out(mem_ack_in));

    // Free-running 100 MHz clock
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task chk_bit(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit

    task chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    task results;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // Monitor: every accepted handshake and completion against the model queues
    always @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            beats = 0;
        end else if (ce_in) begin
            if (xlate_req_out && xlate_ack_in) begin
                chk_word("xlate_vaddr", vq.pop_front(), xlate_vaddr_out);
            end
            if (mem_req_out && mem_ack_in) begin
                chk_word("mem_addr", mq[0][31:0], mem_addr_out);
                chk_word("mem_op", {30'h0, mq[0][33:32]}, {30'h0, mem_op_out});
                chk_bit("mem_data_zero", 1'b0, |mem_data_out);
                void'(mq.pop_front());
                beats++;
            end
            if (done_out) begin
                chk_bit("fault", fq.pop_front(), fault_out);
                chk_word("beats", cq.pop_front(), beats);
                beats = 0;
            end
        end
    end

    // Entered at a falling edge; leaves at a falling edge with the unit ready
    task run_op(input logic [31:0] insn, input logic [31:0] base, input logic hit,
                input logic [31:0] va, input logic [1:0] op, input int nb);
        int k;
        logic [31:0] blk;
        insn_in = insn;
        base_source_reg_in = base;
        insn_valid_in = 1;
        ce_in = 1;
        #1 chk_bit("hit", hit, insn_hit_out);
        if (hit) begin
            blk = (va + XOFF) & ~(BLK - 1);
            vq.push_back(va);
            fq.push_back(fault_mode);
            cq.push_back(fault_mode ? 0 : nb);
            for (k = 0; k < nb && !fault_mode; k++) mq.push_back({op, blk + k * BEAT});
        end
        @(negedge sys_clk_in);
        insn_valid_in = 0;
        if (!hit) chk_bit("no_xlate", 1'b0, xlate_req_out);
        k = 0;
        while (insn_ready_out !== 1'b1 && k < 500) begin
            ce_in = ($random(seed) & 3) != 0;
            @(negedge sys_clk_in);
            k++;
        end
        // A unit that never comes back to idle is a failure, not a silent skip
        if (insn_ready_out !== 1'b1) begin
            err_count++;
            results();
        end
    endtask : run_op

    // One random operation, legal or not recognised
    task rand_op;
        logic [31:0] base;
        logic [6:0] hi;
        logic [4:0] rs;
        int c;
        int h;
        c = $random(seed) & 7;
        h = (c - 2) % 3;
        base = $random(seed);
        hi = $random(seed);
        rs = $random(seed);
        fault_mode = ($random(seed) & 7) == 0;
        slow = $random(seed);
        if (c < 2) run_op({cbo_pkg::CBO_ZERO_FN, rs, cbo_pkg::F3_CBO, 5'h00,
            cbo_pkg::OPC_MISC_MEM}, base, 1, base, cbo_pkg::MEM_ZERO, BLK / BEAT);
        else if (c < 5) run_op({hi, sel_t[h], rs, cbo_pkg::F3_OR_IMM, 5'h00,
            cbo_pkg::OPC_IMM_ALU}, base, 1, base + {{20{hi[6]}}, hi, 5'h00}, op_t[h], 1);
        else if (c == 5) run_op({hi, 5'h02, rs, 3'h6, 5'h00, 7'h13}, base, 0, 0, 0, 0);
        else if (c == 6) run_op({hi, 5'h01, rs, 3'h6, 5'h04, 7'h13}, base, 0, 0, 0, 0);
        else run_op({12'h005, rs, 3'h2, 5'h00, 7'h0f}, base, 0, 0, 0, 0);
    endtask : rand_op

    // Main sequence: reset, random traffic, reset mid-operation, recovery
    initial begin
        repeat (4) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        resetn_in = 1;
        repeat (120) rand_op();
        insn_in = {cbo_pkg::CBO_ZERO_FN, 5'h01, cbo_pkg::F3_CBO, 5'h00, cbo_pkg::OPC_MISC_MEM};
        insn_valid_in = 1;
        ce_in = 1;
        // Block-zero in flight when reset hits: translation and first beat are seen
        vq.push_back(base_source_reg_in);
        mq.push_back({cbo_pkg::MEM_ZERO, (base_source_reg_in + XOFF) & ~(BLK - 1)});
        fault_mode = 0;
        slow = 0;
        @(negedge sys_clk_in);
        insn_valid_in = 0;
        repeat (2) @(negedge sys_clk_in);
        resetn_in = 0;
        @(negedge sys_clk_in);
        resetn_in = 1;
        chk_bit("ready_after_reset", 1'b1, insn_ready_out);
        chk_bit("mem_req_after_reset", 1'b0, mem_req_out);
        chk_bit("done_after_reset", 1'b0, done_out);
        vq.delete();
        mq.delete();
        repeat (8) rand_op();
        // Enable stays high so the last completion pulse is taken
        ce_in = 1;
        repeat (4) @(negedge sys_clk_in);
        chk_word("left_over", 0, vq.size() + mq.size() + fq.size() + cq.size());
        results();
    end

    // Watchdog sized well beyond the longest stalled run
    initial begin
        repeat (60000) @(posedge sys_clk_in);
        err_count++;
        results();
    end
endmodule : cbo_unit_tb_top
